// ===== rtl/dwr_pkg.sv
// constants, codes and types for the drive warning reporter
package dwr_pkg;
  localparam logic [15:0] ERROR_CODE_OBJECT_IDX = 16'h603F;
  localparam logic [15:0] DRIVE_STATUS_WORD_IDX = 16'h6041;
  localparam int          STATUS_WARN_BIT       = 7;
  localparam logic [15:0] CODE_NONE             = 16'h0000;
  localparam logic [15:0] CODE_DEV              = 16'h0900;
  localparam logic [15:0] CODE_DEV_SON          = 16'h0901;
  localparam logic [15:0] CODE_OVERLOAD         = 16'h0910;
  localparam logic [15:0] CODE_VIBRATION        = 16'h0911;
  localparam logic [15:0] CODE_CTRL_TEMP        = 16'h0912;
  localparam logic [15:0] CODE_PWR_TEMP         = 16'h0913;
  localparam logic [15:0] CODE_REGEN            = 16'h0920;
  localparam logic [15:0] CODE_DBRAKE           = 16'h0921;
  localparam logic [15:0] CODE_FAN              = 16'h0923;
  localparam logic [15:0] CODE_BATTERY          = 16'h0930;
  localparam logic [15:0] CODE_OVERHEAT         = 16'h093B;
  localparam logic [15:0] CODE_RIPPLE           = 16'h0942;
  localparam logic [15:0] CODE_UNDERVOLT        = 16'h0971;
  localparam logic [15:0] CODE_OVERTRAVEL       = 16'h09A0;
  localparam logic [15:0] CODE_MAINT            = 16'h09B0;
  localparam logic [15:0] CODE_SAFETY_BASE      = 16'h09C0;
  localparam logic [3:0]  SAFETY_LAST           = 4'h9;
  localparam logic [7:0]  PERCENT_DIV           = 8'h64;
  // digit positions inside the selection parameters (4 bits per digit)
  localparam int          DIGIT_BATTERY         = 0;
  localparam int          DIGIT_UNDERVOLT       = 1;
  localparam int          DIGIT_GLOBAL          = 2;
  localparam int          DIGIT_RIPPLE          = 1;
  localparam int          DIGIT_OVERTRAVEL      = 3;
  localparam int          DIGIT_MAINT           = 0;
  localparam int          DIGIT_VIBRATION       = 0;
  localparam logic [3:0]  VIB_MODE_WARN         = 4'h1;
  localparam logic [3:0]  VIB_MODE_ALARM        = 4'h2;
  localparam logic [3:0]  PANEL_CHAR_WARN       = 4'hA;
  localparam logic [3:0]  PANEL_CHAR_BLANK      = 4'hF;
  localparam int          CLOCK_HZ              = 10000000;
  localparam int          PANEL_CHAR_MS         = 500;
  localparam int          PANEL_CHAR_CYCLES     = CLOCK_HZ / 1000 * PANEL_CHAR_MS;
  localparam int          NUM_WARN              = 26;
  typedef enum logic [2:0] {
    DWR_PANEL_IDLE,
    DWR_PANEL_LETTER,
    DWR_PANEL_HUND,
    DWR_PANEL_TENS,
    DWR_PANEL_ONES,
    DWR_PANEL_GAP
  } dwr_panel_e;
endpackage

// ===== rtl/dwr_warning_reporter.sv
// drive warning reporter: detection, code select, status, emergency and panel
// Summary of operation
// - status word bit 7 is one while any warning exists, else zero
// - active warning code is held in the error-code object for readout
// - a cycle with any new warning occurrence pulses one emergency notification request
// - 900h when deviation exceeds alarm level times percent over 100
// - 901h when deviation at servo-on exceeds level times percent over 100
// - 910h is raised from the early overload indication
// - vibration gives 911h or an alarm as the vibration selection digit says
// - 912h for control board temperature, 913h for power board temperature
// - precursors: 920h regeneration, 921h brake, 971h undervoltage
// - 923h when fan stops, 930h on low battery voltage
// - 93Bh when overheat input level exceeds the overheat warning level
// - 942h when encoder ripple data differs from the drive copy
// - 9A0h on overtravel while servo is on
// - 9b0h when a consumable part reaches end of service life
// - global digit gates warnings except 971h and 9A0h
// - 9A0h gated only by overtravel digit, 971h only by undervoltage digit
// - 911h, 930h, 942h, 9b0h need global digit and their own digit
// - safety module warnings 9C0h to 9C9h can be reported
// - panel shows the warning code one character at a time
`timescale 1ns/10ps
module dwr_warning_reporter
#(
  parameter int PANEL_CYCLES = dwr_pkg::PANEL_CHAR_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [15:0] warning_select_param,
  input  wire logic [15:0] overtravel_warn_select_param,
  input  wire logic [15:0] maintenance_warn_select_param,
  input  wire logic [15:0] vibration_detect_select_param,
  input  wire logic [15:0] ripple_mismatch_select_param,
  input  wire logic [31:0] deviation_alarm_level_param,
  input  wire logic [15:0] deviation_warn_percent_param,
  input  wire logic [31:0] servo_on_deviation_level_param,
  input  wire logic [15:0] servo_on_deviation_percent_param,
  input  wire logic [15:0] overheat_warn_level_param,
  input  wire logic [15:0] overheat_sense_input,
  input  wire logic [31:0] position_deviation,
  input  wire logic        servo_on,
  input  wire logic        overload_early,
  input  wire logic        vibration_detect,
  input  wire logic        ctrl_board_temp_bad,
  input  wire logic        power_board_temp_bad,
  input  wire logic        regen_overload_early,
  input  wire logic        brake_overload_early,
  input  wire logic        fan_stopped,
  input  wire logic        battery_low,
  input  wire logic        ripple_data_mismatch,
  input  wire logic        undervoltage_early,
  input  wire logic        overtravel_detect,
  input  wire logic        part_life_end,
  input  wire logic        safety_module_fitted,
  input  wire logic [9:0]  safety_warn_req,
  input  wire logic [15:0] object_index,
  output logic      [15:0] object_data,
  output logic      [15:0] drive_status_word,
  output logic      [15:0] error_code_object,
  output logic             vibration_alarm,
  output logic             emergency_req,
  output logic      [15:0] emergency_code,
  output logic      [3:0]  panel_char,
  output logic             panel_blank
);
  import dwr_pkg::*;

  logic [NUM_WARN-1:0] warn_vec;
  logic [NUM_WARN-1:0] warn_prev;
  logic [15:0]         code_tab [NUM_WARN];
  logic                glob_en;
  logic [47:0]         dev_lim;
  logic [47:0]         son_lim;
  logic                servo_on_d;
  logic                son_dev_hold;
  logic [15:0]         next_code;
  logic                any_warn;
  dwr_panel_e          panel_state;
  logic [31:0]         panel_cnt;
  logic                panel_tick;
  logic [15:0]         panel_code;

  function automatic logic [3:0] digit(input logic [15:0] p, input int idx);
    digit = p[idx*4 +: 4];
  endfunction

  function automatic logic on_digit(input logic [15:0] p, input int idx);
    on_digit = (p[idx*4 +: 4] != 4'h0);
  endfunction

  assign glob_en    = on_digit(warning_select_param, DIGIT_GLOBAL);
  // limit = level * percent / 100, compared as deviation*100 > level*percent
  assign dev_lim    = deviation_alarm_level_param * deviation_warn_percent_param;
  assign son_lim    = servo_on_deviation_level_param * servo_on_deviation_percent_param;

  // sample deviation at the servo-on edge and hold until servo turns off
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      servo_on_d   <= 1'b0;
      son_dev_hold <= 1'b0;
    end
    else
    begin
      servo_on_d <= servo_on;
      if (servo_on && !servo_on_d)
        son_dev_hold <= (48'(position_deviation) * 48'(PERCENT_DIV)) > son_lim;
      else if (!servo_on)
        son_dev_hold <= 1'b0;
    end
  end

  always_comb
  begin
    warn_vec     = '0;
    warn_vec[0]  = glob_en &&
                   (48'(position_deviation) * 48'(PERCENT_DIV)) > dev_lim;
    warn_vec[1]  = glob_en && son_dev_hold;
    warn_vec[2]  = glob_en && overload_early;
    warn_vec[3]  = glob_en && vibration_detect &&
                   digit(vibration_detect_select_param, DIGIT_VIBRATION) == VIB_MODE_WARN;
    warn_vec[4]  = glob_en && ctrl_board_temp_bad;
    warn_vec[5]  = glob_en && power_board_temp_bad;
    warn_vec[6]  = glob_en && regen_overload_early;
    warn_vec[7]  = glob_en && brake_overload_early;
    warn_vec[8]  = glob_en && fan_stopped;
    warn_vec[9]  = glob_en && battery_low &&
                   on_digit(warning_select_param, DIGIT_BATTERY);
    warn_vec[10] = glob_en && overheat_sense_input > overheat_warn_level_param;
    warn_vec[11] = glob_en && ripple_data_mismatch &&
                   on_digit(ripple_mismatch_select_param, DIGIT_RIPPLE);
    warn_vec[12] = undervoltage_early &&
                   on_digit(warning_select_param, DIGIT_UNDERVOLT);
    warn_vec[13] = overtravel_detect && servo_on &&
                   on_digit(overtravel_warn_select_param, DIGIT_OVERTRAVEL);
    warn_vec[14] = glob_en && part_life_end &&
                   on_digit(maintenance_warn_select_param, DIGIT_MAINT);
    for (int i = 0; i <= int'(SAFETY_LAST); i++)
      warn_vec[15+i] = glob_en && safety_module_fitted && safety_warn_req[i];
  end

  always_comb
  begin
    code_tab[0]  = CODE_DEV;
    code_tab[1]  = CODE_DEV_SON;
    code_tab[2]  = CODE_OVERLOAD;
    code_tab[3]  = CODE_VIBRATION;
    code_tab[4]  = CODE_CTRL_TEMP;
    code_tab[5]  = CODE_PWR_TEMP;
    code_tab[6]  = CODE_REGEN;
    code_tab[7]  = CODE_DBRAKE;
    code_tab[8]  = CODE_FAN;
    code_tab[9]  = CODE_BATTERY;
    code_tab[10] = CODE_OVERHEAT;
    code_tab[11] = CODE_RIPPLE;
    code_tab[12] = CODE_UNDERVOLT;
    code_tab[13] = CODE_OVERTRAVEL;
    code_tab[14] = CODE_MAINT;
    for (int i = 0; i <= int'(SAFETY_LAST); i++)
      code_tab[15+i] = CODE_SAFETY_BASE + 16'(i);
    code_tab[25] = CODE_NONE;
  end

  // table is in ascending code order, so the first set bit is the lowest code
  always_comb
  begin
    next_code = CODE_NONE;
    for (int i = NUM_WARN-1; i >= 0; i--)
      if (warn_vec[i])
        next_code = code_tab[i];
  end

  assign any_warn = |warn_vec;

  // status word and error code
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_status_word <= 16'h0000;
      error_code_object <= CODE_NONE;
    end
    else
    begin
      drive_status_word                  <= 16'h0000;
      drive_status_word[STATUS_WARN_BIT] <= any_warn;
      error_code_object                  <= next_code;
    end
  end

  // vibration alarm path when the selection digit asks for an alarm
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      vibration_alarm <= 1'b0;
    else
      vibration_alarm <= vibration_detect &&
                         digit(vibration_detect_select_param, DIGIT_VIBRATION) == VIB_MODE_ALARM;
  end

  // one emergency request per cycle with any rising warning bit, lowest rising code reported
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      warn_prev      <= '0;
      emergency_req  <= 1'b0;
      emergency_code <= CODE_NONE;
    end
    else
    begin
      warn_prev     <= warn_vec;
      emergency_req <= 1'b0;
      for (int i = NUM_WARN-1; i >= 0; i--)
        if (warn_vec[i] && !warn_prev[i])
        begin
          emergency_req  <= 1'b1;
          emergency_code <= code_tab[i];
        end
    end
  end

  // object readout
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      object_data <= 16'h0000;
    else if (object_index == ERROR_CODE_OBJECT_IDX)
      object_data <= error_code_object;
    else if (object_index == DRIVE_STATUS_WORD_IDX)
      object_data <= drive_status_word;
    else
      object_data <= 16'h0000;
  end

  // panel character timer
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      panel_cnt <= '0;
    else if (panel_state == DWR_PANEL_IDLE || panel_tick)
      panel_cnt <= '0;
    else
      panel_cnt <= panel_cnt + 32'd1;
  end

  assign panel_tick = (panel_cnt == 32'(PANEL_CYCLES - 1));

  // panel sequencer: letter, three digits, blank gap, repeat
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      panel_state <= DWR_PANEL_IDLE;
      panel_code  <= CODE_NONE;
      panel_char  <= PANEL_CHAR_BLANK;
      panel_blank <= 1'b1;
    end
    else
    begin
      case (panel_state)
        DWR_PANEL_IDLE:
        begin
          panel_blank <= 1'b1;
          panel_char  <= PANEL_CHAR_BLANK;
          if (any_warn)
          begin
            panel_code  <= next_code;
            panel_state <= DWR_PANEL_LETTER;
            panel_char  <= PANEL_CHAR_WARN;
            panel_blank <= 1'b0;
          end
        end
        DWR_PANEL_LETTER:
          if (panel_tick)
          begin
            panel_state <= DWR_PANEL_HUND;
            panel_char  <= panel_code[11:8];
          end
        DWR_PANEL_HUND:
          if (panel_tick)
          begin
            panel_state <= DWR_PANEL_TENS;
            panel_char  <= panel_code[7:4];
          end
        DWR_PANEL_TENS:
          if (panel_tick)
          begin
            panel_state <= DWR_PANEL_ONES;
            panel_char  <= panel_code[3:0];
          end
        DWR_PANEL_ONES:
          if (panel_tick)
          begin
            panel_state <= DWR_PANEL_GAP;
            panel_char  <= PANEL_CHAR_BLANK;
            panel_blank <= 1'b1;
          end
        DWR_PANEL_GAP:
          if (panel_tick)
            panel_state <= DWR_PANEL_IDLE;
        default:
          panel_state <= DWR_PANEL_IDLE;
      endcase
    end
  end

endmodule

// ===== sim/dwr_ctrl_model.sv
// network controller model: polls both objects and collects emergency messages
`timescale 1ns/10ps
module dwr_ctrl_model
  import dwr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [15:0] object_data,
  input  wire logic        emergency_req,
  input  wire logic [15:0] emergency_code,
  output logic      [15:0] object_index,
  output logic      [15:0] rd_code,
  output logic      [15:0] rd_status,
  output logic      [7:0]  n_emerg,
  output logic      [15:0] emg_code
);
  logic [2:0] cnt;
  // each object is held four cycles, data taken at the end of the third
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 3'h0;
      object_index <= ERROR_CODE_OBJECT_IDX;
      rd_code <= 16'h0;
      rd_status <= 16'h0;
    end
    else
    begin
      cnt <= cnt + 3'h1;
      object_index <= cnt[2] ? DRIVE_STATUS_WORD_IDX : ERROR_CODE_OBJECT_IDX;
      if (cnt == 3'h3)
        rd_code <= object_data;
      if (cnt == 3'h7)
        rd_status <= object_data;
    end
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      n_emerg <= 8'h0;
      emg_code <= 16'h0;
    end
    else if (emergency_req)
    begin
      n_emerg <= n_emerg + 8'h1;
      emg_code <= emergency_code;
    end
  end
endmodule

// ===== sim/dwr_warning_reporter_chk.sv
// assertion checker for the drive warning reporter
`timescale 1ns/10ps
module dwr_warning_reporter_chk
  import dwr_pkg::*;
#(
  parameter int PANEL_CYCLES = 4
)
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [15:0] warning_select_param,
  input wire logic [15:0] overtravel_warn_select_param,
  input wire logic [15:0] vibration_detect_select_param,
  input wire logic        fan_stopped,
  input wire logic        undervoltage_early,
  input wire logic        vibration_detect,
  input wire logic [15:0] object_index,
  input wire logic [15:0] object_data,
  input wire logic [15:0] drive_status_word,
  input wire logic [15:0] error_code_object,
  input wire logic        vibration_alarm,
  input wire logic        emergency_req,
  input wire logic [15:0] emergency_code,
  input wire logic [3:0]  panel_char,
  input wire logic        panel_blank
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstn);
  logic glob;
  assign glob = warning_select_param[11:8] != 4'h0;
  sequence s_letter;
    (panel_char == PANEL_CHAR_WARN && !panel_blank) [*4];
  endsequence
  sequence s_hund;
    panel_char == 4'h9 && !panel_blank;
  endsequence
  a_flag_matches_code: assert property (drive_status_word[7] == (error_code_object != 16'h0))
    else $error("status flag and error code disagree");
  a_fan_sets_flag: assert property (fan_stopped && glob |=> drive_status_word[7])
    else $error("fan stop not flagged");
  a_undervolt_seen: assert property (undervoltage_early && warning_select_param[7:4] != 4'h0
    |=> error_code_object != 16'h0 && error_code_object <= CODE_UNDERVOLT)
    else $error("undervoltage code missing");
  a_gated_quiet: assert property (!glob && warning_select_param[7:4] == 4'h0
    && overtravel_warn_select_param[15:12] == 4'h0 |=> !drive_status_word[7])
    else $error("warning while detection off");
  a_vib_alarm: assert property (vibration_detect
    && vibration_detect_select_param[3:0] == VIB_MODE_ALARM |=> vibration_alarm)
    else $error("vibration alarm missing");
  a_vib_quiet: assert property (vibration_detect_select_param[3:0] != VIB_MODE_ALARM
    |=> !vibration_alarm)
    else $error("vibration alarm in wrong mode");
  a_emerg_code: assert property (emergency_req |-> drive_status_word[7]
    && emergency_code != 16'h0 && emergency_code >= error_code_object)
    else $error("emergency code inconsistent");
  a_object_status: assert property (object_index == DRIVE_STATUS_WORD_IDX
    |=> object_data == $past(drive_status_word))
    else $error("status object readout wrong");
  a_panel_start: assert property ($fell(panel_blank) |-> s_letter ##1 s_hund)
    else $error("panel sequence start wrong");
endmodule

// ===== sim/tb_dwr_warning_reporter.sv
// testbench for the drive warning reporter
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_dwr_warning_reporter
  import dwr_pkg::*;
;
  localparam logic [15:0] CODES [13] = '{CODE_OVERLOAD, CODE_VIBRATION, CODE_CTRL_TEMP,
    CODE_PWR_TEMP, CODE_REGEN, CODE_DBRAKE, CODE_FAN, CODE_BATTERY, CODE_OVERHEAT,
    CODE_RIPPLE, CODE_UNDERVOLT, CODE_OVERTRAVEL, CODE_MAINT};
  logic        clock = 1'b0, rstn = 1'b0, servo_on = 1'b0, fitted = 1'b0, on;
  logic [12:0] det = '0;
  logic [9:0]  sreq = '0;
  logic [15:0] wsel = '0, ot_sel = '0, mt_sel = '0, vib_sel = '0, rp_sel = '0, pct = '0;
  logic [15:0] so_pct = '0, e, object_index, object_data, status, ecode, emc, rd_code, rd_status;
  logic [15:0] emg_code;
  logic [31:0] lvl = '0, so_lvl = '0, dev = '0, seed = 32'hF3CF, r;
  logic        vib_alarm, emergency_req, panel_blank;
  logic [3:0]  panel_char;
  logic [7:0]  n_emerg, n0;
  int          checks = 0, n_mismatch = 0;
  always #50 clock = ~clock;
  dwr_warning_reporter #(.PANEL_CYCLES(4)) dwr_warning_reporter_i (.clock, .rstn,
    .warning_select_param(wsel), .overtravel_warn_select_param(ot_sel),
    .maintenance_warn_select_param(mt_sel), .vibration_detect_select_param(vib_sel),
    .ripple_mismatch_select_param(rp_sel), .deviation_alarm_level_param(lvl),
    .deviation_warn_percent_param(pct), .servo_on_deviation_level_param(so_lvl),
    .servo_on_deviation_percent_param(so_pct), .overheat_warn_level_param(16'h4000),
    .overheat_sense_input(det[8] ? 16'h8000 : 16'h0100), .position_deviation(dev), .servo_on,
    .overload_early(det[0]), .vibration_detect(det[1]), .ctrl_board_temp_bad(det[2]),
    .power_board_temp_bad(det[3]), .regen_overload_early(det[4]),
    .brake_overload_early(det[5]), .fan_stopped(det[6]), .battery_low(det[7]),
    .ripple_data_mismatch(det[9]), .undervoltage_early(det[10]), .overtravel_detect(det[11]),
    .part_life_end(det[12]), .safety_module_fitted(fitted), .safety_warn_req(sreq),
    .object_index, .object_data, .drive_status_word(status), .error_code_object(ecode),
    .vibration_alarm(vib_alarm), .emergency_req, .emergency_code(emc), .panel_char,
    .panel_blank);
  dwr_ctrl_model dwr_ctrl_model_i (.clock, .rstn, .object_data, .emergency_req,
    .emergency_code(emc), .object_index, .rd_code, .rd_status, .n_emerg, .emg_code);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] exp_code();
    logic [15:0] c;
    logic        g;
    logic        ok;
    c = CODE_NONE;
    g = wsel[11:8] != 4'h0;
    for (int i = 12; i >= 0; i--)
    begin
      case (i)
        1:       ok = g && vib_sel[3:0] == VIB_MODE_WARN;
        7:       ok = g && wsel[3:0] != 4'h0;
        9:       ok = g && rp_sel[7:4] != 4'h0;
        10:      ok = wsel[7:4] != 4'h0;
        11:      ok = ot_sel[15:12] != 4'h0 && servo_on;
        12:      ok = g && mt_sel[3:0] != 4'h0;
        default: ok = g;
      endcase
      if (det[i] && ok)
        c = CODES[i];
    end
    return c;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic settle();
    repeat (12) @(posedge clock);
    #1;
  endtask
  task automatic check_state(input logic [15:0] x);
    `CHK(ecode, x)
    `CHK(status[7], x != CODE_NONE)
    `CHK(rd_status[7], x != CODE_NONE)
    `CHK(rd_code, x)
  endtask
  task automatic wait_panel(input logic blank);
    int k;
    k = 0;
    while (k < 60 && (blank ? panel_blank !== 1'b1 : panel_char !== PANEL_CHAR_WARN))
    begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k == 60)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    settle();
    check_state(CODE_NONE);
    `CHK(panel_blank, 1'b1)
    @(posedge clock);
    servo_on <= 1'b1;
    lvl <= 32'h0000FFFF;
    pct <= 16'h0064;
    so_lvl <= 32'h0000FFFF;
    so_pct <= 16'h0064;
    for (int c = 0; c < 4; c++)
      for (int i = 0; i < 13; i++)
      begin
        @(posedge clock);
        on = c != 2;
        wsel <= c == 1 ? 16'h0011 : (c == 2 ? 16'h0100 : 16'h0111);
        vib_sel <= {15'h0, on};
        ot_sel <= {3'h0, on, 12'h0};
        mt_sel <= {15'h0, on};
        rp_sel <= {11'h0, on, 4'h0};
        r = xs();
        det <= c == 3 ? r[12:0] : 13'h0001 << i;
        n0 = n_emerg;
        settle();
        e = exp_code();
        check_state(e);
        `CHK(n_emerg, n0 + 8'(e != CODE_NONE))
        if (e != CODE_NONE) `CHK(emg_code, e)
        @(posedge clock);
        det <= '0;
        settle();
        check_state(CODE_NONE);
      end
    @(posedge clock);
    vib_sel <= {12'h0, VIB_MODE_ALARM};
    det <= 13'h0002;
    settle();
    `CHK(vib_alarm, 1'b1)
    check_state(CODE_NONE);
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clock);
      r = xs();
      det <= '0;
      lvl <= k < 2 ? 32'h00000064 : {22'h0, r[9:0]};
      pct <= k < 2 ? 16'h0032 : {8'h0, r[17:10]};
      dev <= k < 2 ? 32'h00000032 + 32'(k) : {20'h0, r[29:18]};
      settle();
      e = 64'(dev) * 64'h64 > 64'(lvl) * 64'(pct) ? CODE_DEV : CODE_NONE;
      check_state(e);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      servo_on <= 1'b0;
      so_lvl <= 32'h00000002;
      lvl <= 32'h0000FFFF;
      pct <= 16'h0064;
      dev <= k ? 32'h00000001 : 32'h0000012C;
      settle();
      @(posedge clock);
      servo_on <= 1'b1;
      settle();
      check_state(k ? CODE_NONE : CODE_DEV_SON);
    end
    @(posedge clock);
    dev <= '0;
    fitted <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      sreq <= 10'h001 << i;
      settle();
      check_state(CODE_SAFETY_BASE + 16'(i));
    end
    @(posedge clock);
    sreq <= '0;
    det <= 13'h0040;
    settle();
    wait_panel(1'b1);
    wait_panel(1'b0);
    e = CODE_FAN;
    for (int j = 0; j < 3; j++)
    begin
      repeat (4) @(posedge clock);
      #1;
      `CHK(panel_char, e[11 - 4 * j -: 4])
    end
    repeat (4) @(posedge clock);
    #1;
    `CHK(panel_blank, 1'b1)
    end_of_test();
  end
endmodule
bind dwr_warning_reporter dwr_warning_reporter_chk #(.PANEL_CYCLES(PANEL_CYCLES)) chk_i (
  .clock, .rstn, .warning_select_param, .overtravel_warn_select_param,
  .vibration_detect_select_param, .fan_stopped, .undervoltage_early, .vibration_detect,
  .object_index, .object_data, .drive_status_word, .error_code_object, .vibration_alarm,
  .emergency_req, .emergency_code, .panel_char, .panel_blank);
